// file: hdl/gpc_sequencer.v
// converter sequencer: power-up, single and repeated conversions, averaging, register slave
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "gpc_defines.vh"


module gpc_sequencer #(
    parameter GAP_UNIT_CYCLES = `GPC_GAP_UNIT_NS / `GPC_CLK_PERIOD_NS,
    parameter TICK_W = 17
) (
    input wire CLK_SYS_I,
    input wire RST_I,
    input wire [4:0] ADDRESS_I,
    input wire READ_I,
    input wire WRITE_I,
    input wire [3:0] BYTEENABLE_I,
    input wire [31:0] WRITEDATA_I,
    output reg [31:0] READDATA_O,
    output wire WAITREQUEST_O,
    input wire CONV_DONE_I,
    input wire [9:0] CONV_DATA_I,
    output wire REG_EN_O,
    output wire CONV_EN_O,
    output wire SAMPLE_O,
    output reg CONV_START_O,
    output reg OFFSET_SIGN_O,
    output wire SINGLE_ENDED_O,
    output wire [1:0] SCALE_O,
    output wire [2:0] CHAN_SEL_O,
    output wire [3:0] POS_PIN_O,
    output wire [3:0] INT_SRC_O,
    output wire [3:0] NEG_PIN_O,
    output wire IRQ_O,
    output reg DMA_REQ_O
);

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    localparam [2:0] ST_OFF = 3'h0;
    localparam [2:0] ST_SETTLE = 3'h1;
    localparam [2:0] ST_IDLE = 3'h2;
    localparam [2:0] ST_SAMPLE = 3'h3;
    localparam [2:0] ST_CONVERT = 3'h4;
    localparam [2:0] ST_GAP = 3'h5;

    localparam [TICK_W-1:0] TICK_LAST = GAP_UNIT_CYCLES[TICK_W-1:0] - 1'b1;
    localparam [2:0] SAMPLE_SHIFT = 3'h3;

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    reg power_on_r;
    reg go_r;
    reg auto_repeat_r;
    reg single_ended_r;
    reg offset_cancel_r;
    reg irq_unmask_r;
    reg dma_enable_r;
    reg [2:0] chan_r;
    reg [1:0] neg_r;
    reg [1:0] scale_r;
    reg [3:0] window_r;
    reg [7:0] store_wait_r;
    reg [2:0] avg_exp_r;
    reg [7:0] settle_r;
    reg [7:0] gap_r;
    reg [15:0] result_r;
    reg done_r;
    reg ack_r;

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [16:0] acc_r;
    reg [7:0] idx_r;
    reg [9:0] held_r;
    reg [TICK_W-1:0] tick_cnt_r;
    reg tick_r;

    // ------------------------------------------------------------------
    // converter-side synchronisers
    // ------------------------------------------------------------------
    reg done_s1_r;
    reg done_s2_r;
    reg done_s3_r;
    reg [9:0] data_s1_r;
    reg [9:0] data_s2_r;

    // data settles before done, and both take the same two stages; one clock for bus and control
    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            done_s1_r <= 1'b0;
            done_s2_r <= 1'b0;
            done_s3_r <= 1'b0;
            data_s1_r <= 10'h000;
            data_s2_r <= 10'h000;
        end else begin
            done_s1_r <= CONV_DONE_I;
            done_s2_r <= done_s1_r;
            done_s3_r <= done_s2_r;
            data_s1_r <= CONV_DATA_I;
            data_s2_r <= data_s1_r;
        end
    end

    wire done_rise = done_s2_r & ~done_s3_r;

    // ------------------------------------------------------------------
    // avalon slave: one wait cycle, then answer
    // ------------------------------------------------------------------
    wire req = READ_I | WRITE_I;
    wire wr_now = WRITE_I & ack_r;
    wire [31:0] be_mask = {{8{BYTEENABLE_I[3]}}, {8{BYTEENABLE_I[2]}},
                           {8{BYTEENABLE_I[1]}}, {8{BYTEENABLE_I[0]}}};
    reg [31:0] rd_word;
    wire [31:0] wval = (rd_word & ~be_mask) | (WRITEDATA_I & be_mask);

    always @* begin
        rd_word = 32'h00000000;
        case (ADDRESS_I)
            `GPC_OFS_CTRL: begin
                rd_word[`GPC_CTRL_POWER_ON] = power_on_r;
                rd_word[`GPC_CTRL_GO] = go_r;
                rd_word[`GPC_CTRL_AUTO_REPEAT] = auto_repeat_r;
                rd_word[`GPC_CTRL_SINGLE_ENDED] = single_ended_r;
                rd_word[`GPC_CTRL_OFFSET_CANCEL] = offset_cancel_r;
                rd_word[`GPC_CTRL_IRQ_UNMASK] = irq_unmask_r;
                rd_word[`GPC_CTRL_DMA_ENABLE] = dma_enable_r;
                rd_word[`GPC_CTRL_CHAN_MSB:`GPC_CTRL_CHAN_LSB] = chan_r;
                rd_word[`GPC_CTRL_NEG_MSB:`GPC_CTRL_NEG_LSB] = neg_r;
            end
            `GPC_OFS_CTRL2: begin
                rd_word[`GPC_CTRL2_SCALE_MSB:`GPC_CTRL2_SCALE_LSB] = scale_r;
                rd_word[`GPC_CTRL2_WINDOW_MSB:`GPC_CTRL2_WINDOW_LSB] = window_r;
                rd_word[`GPC_CTRL2_STORE_MSB:`GPC_CTRL2_STORE_LSB] = store_wait_r;
                rd_word[`GPC_CTRL2_AVG_MSB:`GPC_CTRL2_AVG_LSB] = avg_exp_r;
            end
            `GPC_OFS_CTRL3: begin
                rd_word[`GPC_CTRL3_SETTLE_MSB:`GPC_CTRL3_SETTLE_LSB] = settle_r;
                rd_word[`GPC_CTRL3_GAP_MSB:`GPC_CTRL3_GAP_LSB] = gap_r;
            end
            `GPC_OFS_RESULT: begin
                rd_word[15:0] = result_r;
            end
            `GPC_OFS_STATUS: begin
                rd_word[`GPC_STAT_DONE] = done_r;
                rd_word[`GPC_STAT_BUSY] = go_r;
                rd_word[`GPC_STAT_READY] = CONV_EN_O;
            end
            default: begin
                rd_word = 32'h00000000;
            end
        endcase
    end

    assign WAITREQUEST_O = req & ~ack_r;

    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            ack_r <= 1'b0;
            READDATA_O <= 32'h00000000;
        end else begin
            ack_r <= req & ~ack_r;
            if (READ_I && !ack_r) begin
                READDATA_O <= rd_word;
            end
        end
    end

    // ------------------------------------------------------------------
    // timers
    // ------------------------------------------------------------------
    wire settle_zero;
    wire sample_zero;
    wire store_zero;
    wire gap_zero;
    wire enter_sample;
    wire finish;

    gpc_down_counter #(.W(8)) u_settle (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .load_i(state_r == ST_OFF),
        .load_val_i(settle_r),
        .dec_i(state_r == ST_SETTLE),
        .zero_o(settle_zero)
    );

    gpc_down_counter #(.W(7)) u_sample (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .load_i(enter_sample),
        .load_val_i((window_r == 4'h0) ? 7'h00 : ({window_r, SAMPLE_SHIFT} - 7'h04)),
        .dec_i(state_r == ST_SAMPLE),
        .zero_o(sample_zero)
    );

    gpc_down_counter #(.W(8)) u_store (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .load_i(state_r == ST_SAMPLE),
        .load_val_i(store_wait_r),
        .dec_i(state_r == ST_CONVERT),
        .zero_o(store_zero)
    );

    gpc_down_counter #(.W(8)) u_gap (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .load_i(finish),
        .load_val_i(gap_r),
        .dec_i(tick_r && (state_r == ST_GAP)),
        .zero_o(gap_zero)
    );

    // free-running slow tick; a gap waits whole ticks, so the first may come at once and a gap may end up to one unit early
    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            tick_cnt_r <= {TICK_W{1'b0}};
            tick_r <= 1'b0;
        end else begin
            tick_r <= (tick_cnt_r == TICK_LAST);
            if (tick_cnt_r == TICK_LAST) begin
                tick_cnt_r <= {TICK_W{1'b0}};
            end else begin
                tick_cnt_r <= tick_cnt_r + {{(TICK_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // ------------------------------------------------------------------
    // sample taking and averaging
    // ------------------------------------------------------------------
    wire handshake = (store_wait_r == 8'h00);
    wire take = (state_r == ST_CONVERT) && (handshake ? done_rise : store_zero);
    // a fixed wait that ends too early stores the previous sample
    wire [9:0] take_val = (handshake || done_rise) ? data_s2_r : held_r;
    wire [2:0] k_eff = (offset_cancel_r && (avg_exp_r == 3'h0)) ? 3'h1 : avg_exp_r;
    wire [7:0] n_last = (8'h01 << k_eff) - 8'h01;
    wire [16:0] acc_nxt = acc_r + {7'h00, take_val};
    wire [22:0] scaled = {acc_nxt, 6'h00} >> k_eff;
    assign finish = take && (idx_r == n_last);
    wire go_write = wr_now && (ADDRESS_I == `GPC_OFS_CTRL) && wval[`GPC_CTRL_GO];
    wire start = go_write && !go_r && (state_r == ST_IDLE);
    wire relaunch = finish && auto_repeat_r && (gap_r == 8'h00);
    assign enter_sample = start || (take && !finish) || relaunch ||
                          ((state_r == ST_GAP) && gap_zero && auto_repeat_r);

    // ------------------------------------------------------------------
    // sequencer state machine
    // ------------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_OFF: begin
                if (power_on_r) begin
                    state_nxt = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (settle_zero) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (start) begin
                    state_nxt = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (sample_zero) begin
                    state_nxt = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (take) begin
                    if (!finish || relaunch) begin
                        state_nxt = ST_SAMPLE;
                    end else if (auto_repeat_r) begin
                        state_nxt = ST_GAP;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_GAP: begin
                if (!auto_repeat_r) begin
                    state_nxt = ST_IDLE;
                end else if (gap_zero) begin
                    state_nxt = ST_SAMPLE;
                end
            end
            default: begin
                state_nxt = ST_OFF;
            end
        endcase
        if (!power_on_r) begin
            state_nxt = ST_OFF;
        end
    end

    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            state_r <= ST_OFF;
            acc_r <= 17'h00000;
            idx_r <= 8'h00;
            held_r <= 10'h000;
            CONV_START_O <= 1'b0;
            OFFSET_SIGN_O <= 1'b0;
            DMA_REQ_O <= 1'b0;
            result_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            CONV_START_O <= (state_r == ST_SAMPLE) && sample_zero && power_on_r;
            DMA_REQ_O <= finish && dma_enable_r;
            if (done_rise) begin
                held_r <= data_s2_r;
            end
            if (start || (finish && auto_repeat_r)) begin
                acc_r <= 17'h00000;
                idx_r <= 8'h00;
                OFFSET_SIGN_O <= 1'b0;
            end else if (take) begin
                acc_r <= acc_nxt;
                idx_r <= idx_r + 8'h01;
                OFFSET_SIGN_O <= offset_cancel_r & ~OFFSET_SIGN_O;
            end
            if (finish) begin
                result_r <= scaled[15:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // control registers, go and done flags
    // ------------------------------------------------------------------
    wire wr_ctrl = wr_now && (ADDRESS_I == `GPC_OFS_CTRL);
    wire wr_ctrl2 = wr_now && (ADDRESS_I == `GPC_OFS_CTRL2);
    wire wr_ctrl3 = wr_now && (ADDRESS_I == `GPC_OFS_CTRL3);
    wire clr_done = wr_now && (ADDRESS_I == `GPC_OFS_STATUS) &&
                    BYTEENABLE_I[0] && WRITEDATA_I[`GPC_STAT_DONE];
    wire series_end = (finish && !auto_repeat_r) || ((state_r == ST_GAP) && !auto_repeat_r);

    always @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            power_on_r <= 1'b0;
            go_r <= 1'b0;
            auto_repeat_r <= 1'b0;
            single_ended_r <= 1'b0;
            offset_cancel_r <= 1'b0;
            irq_unmask_r <= 1'b0;
            dma_enable_r <= 1'b0;
            chan_r <= 3'h0;
            neg_r <= 2'h0;
            scale_r <= 2'h0;
            window_r <= `GPC_RST_WINDOW;
            store_wait_r <= `GPC_RST_STORE;
            avg_exp_r <= 3'h0;
            settle_r <= `GPC_RST_SETTLE;
            gap_r <= `GPC_RST_GAP;
            done_r <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                power_on_r <= wval[`GPC_CTRL_POWER_ON];
                auto_repeat_r <= wval[`GPC_CTRL_AUTO_REPEAT];
                single_ended_r <= wval[`GPC_CTRL_SINGLE_ENDED];
                offset_cancel_r <= wval[`GPC_CTRL_OFFSET_CANCEL];
                irq_unmask_r <= wval[`GPC_CTRL_IRQ_UNMASK];
                dma_enable_r <= wval[`GPC_CTRL_DMA_ENABLE];
                chan_r <= wval[`GPC_CTRL_CHAN_MSB:`GPC_CTRL_CHAN_LSB];
                neg_r <= wval[`GPC_CTRL_NEG_MSB:`GPC_CTRL_NEG_LSB];
            end
            if (wr_ctrl2) begin
                scale_r <= wval[`GPC_CTRL2_SCALE_MSB:`GPC_CTRL2_SCALE_LSB];
                window_r <= wval[`GPC_CTRL2_WINDOW_MSB:`GPC_CTRL2_WINDOW_LSB];
                store_wait_r <= wval[`GPC_CTRL2_STORE_MSB:`GPC_CTRL2_STORE_LSB];
                avg_exp_r <= wval[`GPC_CTRL2_AVG_MSB:`GPC_CTRL2_AVG_LSB];
            end
            if (wr_ctrl3) begin
                settle_r <= wval[`GPC_CTRL3_SETTLE_MSB:`GPC_CTRL3_SETTLE_LSB];
                gap_r <= wval[`GPC_CTRL3_GAP_MSB:`GPC_CTRL3_GAP_LSB];
            end
            // go stays high across a whole repeat series, gaps included
            if (start) begin
                go_r <= 1'b1;
            end else if (series_end || (state_nxt == ST_OFF)) begin
                go_r <= 1'b0;
            end
            // a completion in the clearing cycle wins
            if (finish) begin
                done_r <= 1'b1;
            end else if (clr_done) begin
                done_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // analog front-end controls
    // ------------------------------------------------------------------
    assign REG_EN_O = (state_r != ST_OFF);
    assign CONV_EN_O = (state_r != ST_OFF) && (state_r != ST_SETTLE);
    assign SAMPLE_O = (state_r == ST_SAMPLE);
    assign SINGLE_ENDED_O = single_ended_r;
    assign SCALE_O = scale_r;
    assign CHAN_SEL_O = chan_r;
    // pins on 0..3; 4 temperature, 5 and 6 battery rails, 7 core supply
    assign POS_PIN_O = chan_r[2] ? 4'h0 : (4'h1 << chan_r[1:0]);
    assign INT_SRC_O = chan_r[2] ? (4'h1 << chan_r[1:0]) : 4'h0;
    assign NEG_PIN_O = single_ended_r ? 4'h0 : (4'h1 << neg_r);
    assign IRQ_O = done_r & irq_unmask_r;

endmodule

`default_nettype wire

// file: hdl/gpc_defines.vh
// register map, field positions, reset values and timing constants of the converter sequencer
`ifndef GPC_DEFINES_VH
`define GPC_DEFINES_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define GPC_OFS_CTRL 5'h00
`define GPC_OFS_CTRL2 5'h04
`define GPC_OFS_CTRL3 5'h08
`define GPC_OFS_RESULT 5'h0C
`define GPC_OFS_STATUS 5'h10

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define GPC_CTRL_POWER_ON 0
`define GPC_CTRL_GO 1
`define GPC_CTRL_AUTO_REPEAT 2
`define GPC_CTRL_SINGLE_ENDED 3
`define GPC_CTRL_OFFSET_CANCEL 4
`define GPC_CTRL_IRQ_UNMASK 5
`define GPC_CTRL_DMA_ENABLE 6
`define GPC_CTRL_CHAN_LSB 8
`define GPC_CTRL_CHAN_MSB 10
`define GPC_CTRL_NEG_LSB 12
`define GPC_CTRL_NEG_MSB 13

// ----------------------------------------------------------------------
// second control register fields
// ----------------------------------------------------------------------
`define GPC_CTRL2_SCALE_LSB 0
`define GPC_CTRL2_SCALE_MSB 1
`define GPC_CTRL2_WINDOW_LSB 4
`define GPC_CTRL2_WINDOW_MSB 7
`define GPC_CTRL2_STORE_LSB 8
`define GPC_CTRL2_STORE_MSB 15
`define GPC_CTRL2_AVG_LSB 16
`define GPC_CTRL2_AVG_MSB 18

// ----------------------------------------------------------------------
// third control register fields
// ----------------------------------------------------------------------
`define GPC_CTRL3_SETTLE_LSB 0
`define GPC_CTRL3_SETTLE_MSB 7
`define GPC_CTRL3_GAP_LSB 8
`define GPC_CTRL3_GAP_MSB 15

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define GPC_STAT_DONE 0
`define GPC_STAT_BUSY 1
`define GPC_STAT_READY 2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define GPC_RST_SETTLE 8'h40
`define GPC_RST_WINDOW 4'h1
`define GPC_RST_STORE 8'h00
`define GPC_RST_GAP 8'h00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define GPC_CLK_PERIOD_NS 10
`define GPC_GAP_UNIT_NS 1024000
`define GPC_SAMPLE_CYCLES_PER_UNIT 8

`endif

// file: hdl/gpc_down_counter.v
// loadable down counter with zero flag, shared by the settle, sample, store and gap timers
`timescale 1ns/10ps
`default_nettype none

module gpc_down_counter #(
    parameter W = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire load_i,
    input wire [W-1:0] load_val_i,
    input wire dec_i,
    output wire zero_o
);

    reg [W-1:0] cnt_r;

    // load beats decrement; holds at zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= {W{1'b0}};
        end else if (load_i) begin
            cnt_r <= load_val_i;
        end else if (dec_i && (cnt_r != {W{1'b0}})) begin
            cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign zero_o = (cnt_r == {W{1'b0}});

endmodule

`default_nettype wire

// file: hdl/gpc_sequencer_fix_note.v
// intentionally minimal: no logic

// file: test/gpc_seq_props.sv
// assertion checker on the converter sequencer ports
`timescale 1ns/10ps
`default_nettype none
module gpc_seq_props (
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic REG_EN_O,
    input wire logic CONV_EN_O,
    input wire logic SAMPLE_O,
    input wire logic CONV_START_O,
    input wire logic SINGLE_ENDED_O,
    input wire logic [2:0] CHAN_SEL_O,
    input wire logic [3:0] POS_PIN_O,
    input wire logic [3:0] INT_SRC_O,
    input wire logic [3:0] NEG_PIN_O,
    input wire logic IRQ_O,
    input wire logic DMA_REQ_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    reg_first_a: assert property ($rose(REG_EN_O) |-> !CONV_EN_O) else $error("converter before regulator");
    conv_needs_reg_a: assert property (CONV_EN_O |-> REG_EN_O) else $error("converter without regulator");
    settle_wait_a: assert property ($rose(CONV_EN_O) |-> $past(REG_EN_O, 8)) else $error("settle too short");
    sample_ready_a: assert property (SAMPLE_O |-> CONV_EN_O) else $error("sampling while not ready");
    sample_len_a: assert property ($rose(SAMPLE_O) |-> SAMPLE_O [*8] ##1 !SAMPLE_O) else $error("sample length");
    start_pulse_a: assert property (CONV_START_O |=> !CONV_START_O && !SAMPLE_O) else $error("start pulse");
    dma_pulse_a: assert property (DMA_REQ_O |=> !DMA_REQ_O) else $error("dma pulse");
    pin_route_a: assert property (CHAN_SEL_O < 4 |-> POS_PIN_O == 4'h1 << CHAN_SEL_O && INT_SRC_O == 4'h0)
        else $error("pin channel route");
    int_route_a: assert property (CHAN_SEL_O > 3 |-> INT_SRC_O == 4'h1 << (CHAN_SEL_O - 4) && POS_PIN_O == 4'h0)
        else $error("internal channel route");
    neg_off_a: assert property (SINGLE_ENDED_O |-> NEG_PIN_O == 4'h0) else $error("negative pin in single-ended");
    cover property ($rose(SAMPLE_O));
    cover property (DMA_REQ_O);
    cover property (IRQ_O);
endmodule
`default_nettype wire

// file: test/gpc_conv_model.sv
// behavioural analog converter core answering start pulses
`timescale 1ns/10ps
`default_nettype none
module gpc_conv_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [9:0] code_i,
    input wire logic [3:0] lat_i,
    output logic done_o,
    output logic [9:0] data_o
);
    int cnt;
    logic [9:0] hold;
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 0;
            done_o <= 1'b0;
            data_o <= 10'h000;
        end else if (start_i) begin
            cnt <= lat_i + 8;
            hold <= code_i;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
            // data settles a cycle ahead of done, then is spoiled in the same cycle that done is released
            if (cnt == 7) data_o <= hold;
            if (cnt == 6) done_o <= 1'b1;
            if (cnt == 1) begin
                done_o <= 1'b0;
                data_o <= ~hold;
            end
        end
    end
endmodule
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
`include "gpc_defines.vh"
module tb;
    localparam int U = 16;
    logic clk = 0, rst = 1, rd = 0, wr = 0, cdone, samp, cst, osgn, se, irq, dma, wreq, regen, conven;
    logic [4:0] adr = 5'h00;
    logic [3:0] pos, isrc, neg, lat = 4'h0;
    logic [31:0] wd = 32'h0, rdat, q, d;
    logic [9:0] cdat, code = 10'h000;
    logic [1:0] scl;
    logic [2:0] ch;
    integer fails = 0, compares = 0, seed = 32'h49b0, starts = 0, last = 0, tot = 0, n, i, g, s0, nsel;
    always #5 clk = ~clk;
    always @(posedge clk) if (cst) begin
        starts <= starts + 1;
        code <= 10'($random(seed));
    end
    always @(posedge cdone) begin
        last = cdat;
        tot = tot + cdat;
    end
    gpc_sequencer #(.GAP_UNIT_CYCLES(U)) dut_u (.CLK_SYS_I(clk), .RST_I(rst), .ADDRESS_I(adr), .READ_I(rd),
        .WRITE_I(wr), .BYTEENABLE_I(4'hF), .WRITEDATA_I(wd), .READDATA_O(rdat), .WAITREQUEST_O(wreq),
        .CONV_DONE_I(cdone), .CONV_DATA_I(cdat), .REG_EN_O(regen), .CONV_EN_O(conven), .SAMPLE_O(samp),
        .CONV_START_O(cst), .OFFSET_SIGN_O(osgn), .SINGLE_ENDED_O(se), .SCALE_O(scl), .CHAN_SEL_O(ch),
        .POS_PIN_O(pos), .INT_SRC_O(isrc), .NEG_PIN_O(neg), .IRQ_O(irq), .DMA_REQ_O(dma));
    gpc_conv_model mdl_u (.clk_i(clk), .rst_i(rst), .start_i(cst), .code_i(code), .lat_i(lat),
        .done_o(cdone), .data_o(cdat));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        compares = compares + 1;
        if (v !== e) begin
            fails = fails + 1;
            $display("MISMATCH %s exp %h got %h", nm, e, v);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] dd);
        n = 0;
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= dd;
        do begin @(posedge clk); n = n + 1; end while (wreq !== 1'b0 && n < 50);
        if (n >= 50) fails = fails + 1;
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic poll(input int b, input logic v);
        i = 0;
        do begin bus(0, `GPC_OFS_STATUS, 0); i = i + 1; end while (q[b] !== v && i < 400);
    endtask
    task automatic wrap_up;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        fails = fails + 1;
        wrap_up;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(0, `GPC_OFS_CTRL3, 0);
        chk("settle", 32'h40, q);
        bus(0, 5'h14, 0);
        chk("unmapped", 32'h0, q);
        bus(1, `GPC_OFS_CTRL, 32'h2);
        bus(0, `GPC_OFS_STATUS, 0);
        chk("go unpowered", 32'h0, q[`GPC_STAT_BUSY]);
        bus(1, `GPC_OFS_CTRL, 32'h1);
        @(negedge clk);
        chk("regulator", 32'h2, {regen, conven});
        @(posedge clk);
        poll(`GPC_STAT_READY, 1'b1);
        chk("ready", 32'h1, conven);
        for (g = 0; g < 2; g = g + 1) begin
            lat <= 4'($random(seed));
            s0 = starts;
            bus(1, `GPC_OFS_CTRL, 32'h43 | (g << 5));
            bus(1, `GPC_OFS_CTRL, 32'h43 | (g << 5));
            bus(0, `GPC_OFS_STATUS, 0);
            chk("busy", 32'h1, q[`GPC_STAT_BUSY]);
            poll(`GPC_STAT_BUSY, 1'b0);
            chk("one start", 1, starts - s0);
            chk("done", 32'h1, q[`GPC_STAT_DONE]);
            chk("irq", g, irq);
            bus(0, `GPC_OFS_RESULT, 0);
            chk("result", {last[9:0], 6'h00}, q[15:0]);
            bus(1, `GPC_OFS_STATUS, 32'h1);
            chk("irq clear", 32'h0, irq);
        end
        for (i = 0; i < 8; i = i + 1) begin
            nsel = $random(seed);
            d = 32'h1 | (i << 8) | (nsel & 32'h3008);
            bus(1, `GPC_OFS_CTRL, d);
            bus(1, `GPC_OFS_CTRL2, 32'h10 | (d[9:8]));
            chk("chan", d[10:8], ch);
            chk("pos", d[10] ? 4'h0 : 4'h1 << d[9:8], pos);
            chk("int", d[10] ? 4'h1 << d[9:8] : 4'h0, isrc);
            chk("neg", d[3] ? 32'h10 : 4'h1 << d[13:12], {se, neg});
            chk("scale", d[9:8], scl);
        end
        bus(1, `GPC_OFS_CTRL2, 32'h10010);
        s0 = starts;
        tot = 0;
        bus(1, `GPC_OFS_CTRL, 32'h13);
        poll(`GPC_STAT_BUSY, 1'b0);
        chk("pair", 2, starts - s0);
        chk("sign back", 0, osgn);
        bus(0, `GPC_OFS_RESULT, 0);
        chk("average", (tot << 6) >> 1, q[15:0]);
        bus(1, `GPC_OFS_CTRL2, 32'h10);
        bus(1, `GPC_OFS_CTRL, 32'h1);
        for (g = 0; g < 3; g = g + 2) begin
            bus(1, `GPC_OFS_CTRL3, 32'h40 | (g << 8));
            s0 = starts;
            bus(1, `GPC_OFS_CTRL, 32'h47);
            n = 0;
            do begin @(negedge clk); n = n + 1; end while (!dma && n < 500);
            n = 0;
            do begin @(negedge clk); n = n + 1; end while (!samp && n < 500);
            chk("gap", 1, n > U * (g - 1) && n <= U * g + 4);
            chk("gap zero", 1, g != 0 || n <= 4);
            do @(negedge clk); while (starts - s0 < 3);
            @(posedge clk);
            bus(1, `GPC_OFS_CTRL, 32'h1);
            poll(`GPC_STAT_BUSY, 1'b0);
            chk("repeats", 1, starts - s0 >= 3);
            bus(0, `GPC_OFS_RESULT, 0);
            chk("latest", {last[9:0], 6'h00}, q[15:0]);
        end
        wrap_up;
    end
endmodule
bind gpc_sequencer gpc_seq_props chk_u (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .REG_EN_O(REG_EN_O),
    .CONV_EN_O(CONV_EN_O), .SAMPLE_O(SAMPLE_O), .CONV_START_O(CONV_START_O), .SINGLE_ENDED_O(SINGLE_ENDED_O),
    .CHAN_SEL_O(CHAN_SEL_O), .POS_PIN_O(POS_PIN_O), .INT_SRC_O(INT_SRC_O), .NEG_PIN_O(NEG_PIN_O),
    .IRQ_O(IRQ_O), .DMA_REQ_O(DMA_REQ_O));
`default_nettype wire
